// ---- logic/adcst_ctrl.sv ----
// acquisition control: polled conversion, timed scans, trigger modes
// assumes apb master on clk_in; converter busy and triggers are pins
//
// Summary of operation
// - one conversion per polled command, busy status
// - per-channel enable, gain, polarity held always
// - 24-bit interval counter launches each scan
// - 24-bit post-scan counter sets scans after
// - scan launch fires simultaneous conversion start
// - base clock selects internal or external
// - four trigger sources, exactly one selected
// - trigger on rising edge of source
// - pre, post, middle, delay trigger modes
// - pre mode: scan from start to trigger
// - pre mode keeps last M scans only
// - pre mode takes no scans after trigger
// - stored total equals all channels times M, disabled stored as zero
// - running conversion finishes, counted among kept
// - early trigger stores fewer than M scans
// - guard bit blocks trigger until M scans
// - each completed result enters data FIFO unless full (pre-trigger rotation excepted)
module adcst_ctrl
    import adcst_pkg::*;
#(
    parameter int DEPTH = 16, // scans held in the data FIFO
    parameter int AW = 4 // FIFO address width
) (
    input wire logic clk_in, // 40 MHz system clock
    input wire logic rstn_in, // sync reset, low active
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic external_base_clock_in, // external base clock
    input wire logic ext_analog_trig_in, // analog comparator trigger
    input wire logic ext_digital_trig_in, // digital trigger pin
    input wire logic system_sync_bus_in, // sync bus trigger
    input wire logic conv_busy_in, // converters busy, high
    input wire logic [NUM_CH*SAMPLE_W-1:0] adc_data_in, // results
    output logic conv_start_out, // start all converters, pulse
    output adcst_chcfg_type [NUM_CH-1:0] ch_cfg_out // channel setup
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic clk_sel, next_clk_sel, guard, next_guard;
    adcst_src_type trig_src, next_trig_src;
    adcst_mode_type trig_mode, next_trig_mode;
    logic [SI_W-1:0] si_count, next_si_count;
    logic [PSC_W-1:0] post_scan_count, next_post_scan_count;
    logic [PRE_W-1:0] pre_count, next_pre_count;
    adcst_chcfg_type [NUM_CH-1:0] next_ch_cfg;
    logic [31:0] next_prdata;
    logic wr, rd, cmd_conv, cmd_start, cmd_stop, cmd_swtrig;
    adcst_state_type state, next_state;
    logic [SI_W-1:0] si_cnt, next_si_cnt;
    logic [PSC_W-1:0] post_left, next_post_left;
    logic [PRE_W-1:0] scans_done, next_scans_done;
    logic conv_active, next_conv_active, trig_seen, next_trig_seen;
    logic overflow, next_overflow, next_conv_start;
    logic base_tick, launch, done, trig_ev, trig_ok, launch_ok;
    logic [4:0] pin_level, pin_rise, pin_fall;
    logic [NUM_CH*SAMPLE_W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] count, next_count;
    logic push, pop, sw_pop, drop, clear;
    logic [NUM_CH*SAMPLE_W-1:0] masked;

    // map of decoded offsets, used by the slave and the error answer
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return a == OFS_CTRL || a == OFS_SI || a == OFS_PSC ||
            a == OFS_PRE || a == OFS_CHCFG || a == OFS_STATUS ||
            a == OFS_DATA01 || a == OFS_DATA23;
    endfunction : addr_ok

    // ------------------------------------------------------------
    // pin synchronisers: triggers, external base clock, busy
    // ------------------------------------------------------------
    adcst_sync #(.W(5)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in({conv_busy_in, external_base_clock_in, system_sync_bus_in,
            ext_digital_trig_in, ext_analog_trig_in}),
        .level_out(pin_level),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // ------------------------------------------------------------
    // apb slave: zero wait states, read data caught in setup
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign wr = psel && penable && pwrite && addr_ok(paddr);
    assign rd = psel && penable && !pwrite;
    assign cmd_conv = wr && paddr == OFS_CTRL && pwdata[CTL_CONV];
    assign cmd_start = wr && paddr == OFS_CTRL && pwdata[CTL_START];
    assign cmd_stop = wr && paddr == OFS_CTRL && pwdata[CTL_STOP];
    assign cmd_swtrig = wr && paddr == OFS_CTRL && pwdata[CTL_SWTRIG];
    assign sw_pop = rd && paddr == OFS_DATA23 && count != '0;

    // configuration registers and read mux
    always_comb begin
        next_clk_sel = clk_sel;
        next_guard = guard;
        next_trig_src = trig_src;
        next_trig_mode = trig_mode;
        next_si_count = si_count;
        next_post_scan_count = post_scan_count;
        next_pre_count = pre_count;
        next_ch_cfg = ch_cfg_out;
        next_prdata = prdata;
        if (wr && paddr == OFS_CTRL) begin
            next_clk_sel = pwdata[CTL_CLKSEL];
            next_trig_src = adcst_src_type'(pwdata[CTL_SRC_LO +: 2]);
            next_trig_mode = adcst_mode_type'(pwdata[CTL_MODE_LO +: 2]);
            next_guard = pwdata[CTL_GUARD];
        end
        if (wr && paddr == OFS_SI) next_si_count = pwdata[SI_W-1:0];
        if (wr && paddr == OFS_PSC) begin
            next_post_scan_count = pwdata[PSC_W-1:0];
        end
        if (wr && paddr == OFS_PRE) next_pre_count = pwdata[PRE_W-1:0];
        if (wr && paddr == OFS_CHCFG) begin
            next_ch_cfg = pwdata[NUM_CH*4-1:0];
        end
        if (psel && !penable) begin
            case (paddr)
                OFS_CTRL: next_prdata = {23'h0, guard, trig_mode,
                    trig_src, clk_sel, 3'h0};
                OFS_SI: next_prdata = {8'h00, si_count};
                OFS_PSC: next_prdata = {8'h00, post_scan_count};
                OFS_PRE: next_prdata = {16'h0000, pre_count};
                OFS_CHCFG: next_prdata = {16'h0000, ch_cfg_out};
                OFS_STATUS: next_prdata = {scans_done,
                    3'h0, count, 3'h0, overflow, count == '0,
                    trig_seen, state != ST_IDLE, conv_active};
                OFS_DATA01: next_prdata = mem[rptr][31:0];
                OFS_DATA23: next_prdata = mem[rptr][63:32];
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            clk_sel <= 1'b0;
            guard <= 1'b0;
            trig_src <= TSRC_SOFT;
            trig_mode <= TMODE_PRE;
            si_count <= RST_SI;
            post_scan_count <= RST_PSC;
            pre_count <= RST_PRE;
            ch_cfg_out <= '0;
            prdata <= 32'h00000000;
        end else begin
            clk_sel <= next_clk_sel;
            guard <= next_guard;
            trig_src <= next_trig_src;
            trig_mode <= next_trig_mode;
            si_count <= next_si_count;
            post_scan_count <= next_post_scan_count;
            pre_count <= next_pre_count;
            ch_cfg_out <= next_ch_cfg;
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // acquisition sequencer
    // ------------------------------------------------------------
    // external base clock is sampled, so it must stay well below 40 MHz
    assign base_tick = clk_sel ? pin_rise[3] : 1'b1;
    // selected source only; software source is the command bit
    always_comb begin
        case (trig_src)
            TSRC_SOFT: trig_ev = cmd_swtrig;
            TSRC_ANALOG: trig_ev = pin_rise[0];
            TSRC_DIGITAL: trig_ev = pin_rise[1];
            TSRC_SYNCBUS: trig_ev = pin_rise[2];
            default: trig_ev = 1'b0;
        endcase
    end
    assign done = conv_active && pin_fall[4];
    // pre and middle scan until the trigger, others only after it
    assign launch_ok = !trig_seen ? (trig_mode == TMODE_PRE ||
        trig_mode == TMODE_MIDDLE) :
        (trig_mode != TMODE_PRE && post_left != '0);
    // overlapping starts are withheld rather than corrupting a scan
    assign launch = state == ST_SCAN && launch_ok && base_tick &&
        si_cnt <= 24'h000001 && !conv_active;
    assign trig_ok = trig_ev && !trig_seen &&
        (!guard || scans_done >= pre_count);

    always_comb begin
        next_state = state;
        next_si_cnt = si_cnt;
        next_post_left = post_left;
        next_scans_done = scans_done;
        next_conv_active = conv_active;
        next_trig_seen = trig_seen;
        next_conv_start = 1'b0;
        clear = 1'b0;
        if (base_tick && state == ST_SCAN) begin
            next_si_cnt = (si_cnt <= 24'h000001) ? si_count :
                si_cnt - 24'h000001;
        end
        if (done) begin
            next_conv_active = 1'b0;
            if (scans_done != 16'hFFFF) begin
                next_scans_done = scans_done + 16'h0001;
            end
        end
        case (state)
            ST_IDLE: begin
                if (cmd_conv) begin
                    next_conv_start = 1'b1;
                    next_conv_active = 1'b1;
                    next_state = ST_POLL;
                end else if (cmd_start) begin
                    clear = 1'b1;
                    next_scans_done = '0;
                    next_trig_seen = 1'b0;
                    next_si_cnt = si_count;
                    next_post_left = post_scan_count;
                    next_state = (trig_mode == TMODE_PRE ||
                        trig_mode == TMODE_MIDDLE) ? ST_SCAN : ST_ARM;
                end
            end
            ST_POLL: begin
                if (done) next_state = ST_IDLE;
            end
            ST_ARM: begin
                if (trig_ev) begin
                    next_trig_seen = 1'b1;
                    next_state = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (trig_ok) next_trig_seen = 1'b1;
                if (launch) begin
                    next_conv_start = 1'b1;
                    next_conv_active = 1'b1;
                    if (trig_seen) next_post_left = post_left - 24'h000001;
                end
                // a running conversion is allowed to finish first
                if (trig_seen && !launch_ok && !conv_active) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (cmd_stop) begin
            next_state = ST_IDLE;
            next_conv_active = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state <= ST_IDLE;
            si_cnt <= '0;
            post_left <= '0;
            scans_done <= '0;
            conv_active <= 1'b0;
            trig_seen <= 1'b0;
            conv_start_out <= 1'b0;
        end else begin
            state <= next_state;
            si_cnt <= next_si_cnt;
            post_left <= next_post_left;
            scans_done <= next_scans_done;
            conv_active <= next_conv_active;
            trig_seen <= next_trig_seen;
            conv_start_out <= next_conv_start;
        end
    end

    // ------------------------------------------------------------
    // data FIFO of whole scans; disabled channels stored as zero
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            masked[c*SAMPLE_W +: SAMPLE_W] = ch_cfg_out[c].en ?
                adc_data_in[c*SAMPLE_W +: SAMPLE_W] : 16'h0000;
        end
    end
    // before the trigger only the newest pre_count scans survive
    // in pre mode the scan finishing after the trigger still rotates
    assign drop = done && state == ST_SCAN && count != '0 &&
        (!trig_seen || trig_mode == TMODE_PRE) &&
        ({11'h000, count} >= pre_count || count == DEPTH[AW:0]);
    assign push = done && (drop || count != DEPTH[AW:0]);
    assign pop = sw_pop || drop;

    always_comb begin
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // overflow sets over a simultaneous clear from a new start
        next_overflow = (done && !push) || (overflow && !clear);
        if (clear) begin
            next_wptr = '0;
            next_rptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            overflow <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            overflow <= next_overflow;
        end
        if (push) mem[wptr] <= masked;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_poll_one;
        @(posedge clk_in) disable iff (!rstn_in)
        state == ST_IDLE && cmd_conv && !cmd_stop |=> conv_start_out
            ##1 !conv_start_out [*2];
    endproperty
    a_poll_one: assert property (p_poll_one)
        else $error("polled command did not give one start");
    property p_poll_busy;
        @(posedge clk_in) disable iff (!rstn_in)
        conv_start_out && state == ST_POLL |-> conv_active;
    endproperty
    a_poll_busy: assert property (p_poll_busy)
        else $error("busy status low during polled conversion");
    property p_chcfg;
        @(posedge clk_in) disable iff (!rstn_in)
        !(wr && paddr == OFS_CHCFG) |=> $stable(ch_cfg_out);
    endproperty
    a_chcfg: assert property (p_chcfg)
        else $error("channel setup changed without a write");
    property p_reload;
        @(posedge clk_in) disable iff (!rstn_in)
        launch |=> si_cnt == $past(si_count);
    endproperty
    a_reload: assert property (p_reload)
        else $error("interval counter did not reload");
    property p_launch_start;
        @(posedge clk_in) disable iff (!rstn_in)
        launch && !cmd_stop |=> conv_start_out && conv_active;
    endproperty
    a_launch_start: assert property (p_launch_start)
        else $error("launch did not start conversion");
    property p_pre_stop;
        @(posedge clk_in) disable iff (!rstn_in)
        trig_mode == TMODE_PRE && trig_seen |-> !launch;
    endproperty
    a_pre_stop: assert property (p_pre_stop)
        else $error("scan launched after pre trigger");
    property p_guard;
        @(posedge clk_in) disable iff (!rstn_in)
        state == ST_SCAN && guard && scans_done < pre_count
            && !trig_seen |=> !trig_seen;
    endproperty
    a_guard: assert property (p_guard)
        else $error("trigger accepted before guard count");
    property p_keep;
        @(posedge clk_in) disable iff (!rstn_in)
        state == ST_SCAN && !trig_seen && pre_count != '0 |->
            {11'h000, count} <= pre_count;
    endproperty
    a_keep: assert property (p_keep)
        else $error("more than pre count scans retained");
    property p_finish;
        @(posedge clk_in) disable iff (!rstn_in)
        state == ST_SCAN && conv_active && !cmd_stop |=>
            state == ST_SCAN;
    endproperty
    a_finish: assert property (p_finish)
        else $error("scan ended while converting");
    property p_push;
        @(posedge clk_in) disable iff (!rstn_in)
        done && !clear && count != DEPTH[AW:0] && !pop |=>
            count == $past(count) + 1'b1;
    endproperty
    a_push: assert property (p_push)
        else $error("completed scan not stored");
    c_poll: cover property (@(posedge clk_in) state == ST_POLL ##[1:20]
        state == ST_IDLE);
    c_pre: cover property (@(posedge clk_in)
        trig_mode == TMODE_PRE && trig_ok);
    c_drop: cover property (@(posedge clk_in) drop);
    c_post: cover property (@(posedge clk_in) state == ST_ARM ##1
        state == ST_SCAN);

endmodule : adcst_ctrl

// ---- logic/adcst_pkg.sv ----
// shared constants and types for the scan and trigger control block
// assumes one 40 MHz clock and a 32-bit apb register port
package adcst_pkg;

    // ------------------------------------------------------------
    // clock and widths
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000; // on-board base clock
    localparam int NUM_CH = 4;
    localparam int SAMPLE_W = 16;
    localparam int SI_W = 24; // scan interval counter
    localparam int PSC_W = 24; // post-scan counter
    localparam int PRE_W = 16; // pre-scan counter
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SI = 8'h04;
    localparam logic [7:0] OFS_PSC = 8'h08;
    localparam logic [7:0] OFS_PRE = 8'h0C;
    localparam logic [7:0] OFS_CHCFG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_DATA01 = 8'h18;
    localparam logic [7:0] OFS_DATA23 = 8'h1C; // read pops one scan

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTL_CONV = 0; // write 1: one polled conversion
    localparam int CTL_START = 1; // write 1: start scan operation
    localparam int CTL_STOP = 2; // write 1: abort
    localparam int CTL_CLKSEL = 3; // 1: external base clock
    localparam int CTL_SRC_LO = 4; // 2-bit trigger source
    localparam int CTL_MODE_LO = 6; // 2-bit trigger mode
    localparam int CTL_GUARD = 8; // pre-count guard
    localparam int CTL_SWTRIG = 9; // write 1: software trigger

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_RUN = 1;
    localparam int ST_TRIG = 2;
    localparam int ST_EMPTY = 3;
    localparam int ST_OVF = 4;
    localparam int ST_CNT_LO = 8;
    localparam int ST_SCANS_LO = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [SI_W-1:0] RST_SI = 24'h0000A0;
    localparam logic [PSC_W-1:0] RST_PSC = 24'h000000;
    localparam logic [PRE_W-1:0] RST_PRE = 16'h0001;

    typedef enum logic [1:0] {
        TSRC_SOFT = 2'b00,
        TSRC_ANALOG = 2'b01,
        TSRC_DIGITAL = 2'b10,
        TSRC_SYNCBUS = 2'b11
    } adcst_src_type;

    typedef enum logic [1:0] {
        TMODE_PRE = 2'b00,
        TMODE_POST = 2'b01,
        TMODE_MIDDLE = 2'b10,
        TMODE_DELAY = 2'b11
    } adcst_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POLL = 2'b01,
        ST_ARM = 2'b10,
        ST_SCAN = 2'b11
    } adcst_state_type;

    // per-channel input setup
    typedef struct packed {
        logic pol; // 1: bipolar
        logic [1:0] gain;
        logic en;
    } adcst_chcfg_type;

endpackage : adcst_pkg

// ---- logic/adcst_sync.sv ----
// three-stage synchroniser with agreement filter and edge pulses
// assumes inputs arrive asynchronously to clk_in
module adcst_sync #(
    parameter int W = 1
) (
    input wire logic clk_in, // system clock
    input wire logic rstn_in, // sync reset, low active
    input wire logic [W-1:0] d_in, // asynchronous levels
    output logic [W-1:0] level_out, // filtered level
    output logic [W-1:0] rise_out, // one-cycle rise pulse
    output logic [W-1:0] fall_out // one-cycle fall pulse
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_level;

    // ------------------------------------------------------------
    // level follows once the second and third stages agree
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_level[i] = (s2[i] == s3[i]) ? s3[i] : level_out[i];
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level_out <= '0;
        end else begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
            level_out <= next_level;
        end
    end

    assign rise_out = next_level & ~level_out;
    assign fall_out = ~next_level & level_out;

endmodule : adcst_sync

// ---- tb/adcst_conv_model.sv ----
// behavioural bank of four converters answering start pulses
// assumes the controller's start pulse is one clk_in cycle wide
module adcst_conv_model
    import adcst_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic start_in, // start all converters
    output logic busy_out = 1'b0, // converting, high
    output logic [NUM_CH*SAMPLE_W-1:0] data_out = '0 // results
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int k = 0;
    // busy for six cycles; results toggle meanwhile so stale data fails
    always @(posedge clk_in) begin
        if (start_in) begin
            cnt <= 6;
            busy_out <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
            data_out <= ~data_out;
        end else if (busy_out) begin
            busy_out <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                data_out[i*16 +: 16] <= 16'(4 * k + i);
            end
            k <= k + 1;
        end
    end
endmodule : adcst_conv_model

// ---- tb/adc_scan_trigger_control_tb_top.sv ----
// apb bench for the scan and trigger control block
// assumes the converter model answers every start pulse
module adc_scan_trigger_control_tb_top
    import adcst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, rstn_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, a;
    logic pready, pslverr, start, busy, err;
    logic xclk = 0, dtrig = 0; // external base clock, digital trigger pin
    logic [63:0] adc;
    adcst_chcfg_type [3:0] cfg;
    int fail_count = 0, checks_done = 0, starts = 0, cyc = 0, last = 0;
    int gap = 0, n = 0;
    always #12.5 clk_in = ~clk_in;
    // launch count and spacing of the last two launches
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        xclk <= cyc[2]; // continuous 5 MHz, inside 1-40 MHz
        if (start) begin
            starts <= starts + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end
    adcst_ctrl i_adcst_ctrl (.clk_in, .rstn_in, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .external_base_clock_in(xclk), .ext_analog_trig_in(1'b0),
        .ext_digital_trig_in(dtrig), .system_sync_bus_in(1'b0),
        .conv_busy_in(busy), .adc_data_in(adc), .conv_start_out(start),
        .ch_cfg_out(cfg));
    adcst_conv_model i_adcst_conv_model (.clk_in, .start_in(start),
        .busy_out(busy), .data_out(adc));
    // ------------------------------------------------------------
    // bus tasks; a release edge always separates two transfers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] ad,
            input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1 && t < 20) begin
            t++;
            @(posedge clk_in);
        end
        if (t == 20) begin
            $display("unexpected at %0t: no pready", $time);
            fail_count++;
            conclude();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(r, exp);
    endtask : rd
    // bounded poll of one status bit
    task automatic poll(input int b, input logic v);
        int t;
        for (t = 0; t < 300; t++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (r[b] === v) break;
        end
        if (t == 300) begin
            $display("unexpected at %0t: status poll timed out", $time);
            fail_count++;
            conclude();
        end
    endtask : poll
    initial begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(OFS_SI, 32'h000000A0);
        rd(OFS_PSC, 32'h00000000);
        rd(OFS_PRE, 32'h00000001);
        rd(8'h40, 32'h00000000);
        chk(err, 32'h1);
        apb(1'b1, OFS_CHCFG, 32'h0000D3A9);
        apb(1'b1, OFS_CTRL, 32'h00000001);
        poll(ST_BUSY, 1'b0);
        chk(cfg, 32'h0000D3A9);
        chk(starts, 32'h1);
        rd(OFS_DATA01, 32'h00000000);
        rd(OFS_DATA23, 32'h00030002);
        apb(1'b1, OFS_SI, 32'h00000014);
        apb(1'b1, OFS_PRE, 32'h00000002);
        apb(1'b1, OFS_CTRL, 32'h00000102);
        repeat (120) @(posedge clk_in);
        chk(gap, 32'h14);
        apb(1'b1, OFS_CTRL, 32'h00000300);
        poll(ST_RUN, 1'b0);
        n = starts;
        repeat (60) @(posedge clk_in);
        chk(starts, n);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(r[12:8], 32'h2);
        apb(1'b0, OFS_DATA01, 32'h0);
        a = r;
        apb(1'b0, OFS_DATA23, 32'h0);
        apb(1'b0, OFS_DATA01, 32'h0);
        chk(r[15:0], a[15:0] + 16'h4);
        apb(1'b0, OFS_DATA23, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h00000102);
        apb(1'b1, OFS_CTRL, 32'h00000300);
        rd(OFS_STATUS, 32'h0000000A);
        apb(1'b1, OFS_CTRL, 32'h00000004);
        rd(OFS_STATUS, 32'h00000008);
        apb(1'b1, OFS_CTRL, 32'h00000002);
        apb(1'b1, OFS_CTRL, 32'h00000200);
        poll(ST_RUN, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(r[12:8] < 5'h2, 32'h1);
        // post mode on the digital pin, paced by the external base clock
        apb(1'b1, OFS_PSC, 32'h00000003);
        apb(1'b1, OFS_SI, 32'h00000004);
        apb(1'b1, OFS_CTRL, 32'h00000068);
        apb(1'b1, OFS_CTRL, 32'h0000006A);
        n = starts;
        dtrig <= 1'b1;
        poll(ST_RUN, 1'b0);
        chk(starts - n, 32'h3);
        chk(gap, 32'h20);
        rd(OFS_STATUS, 32'h00030304);
        conclude();
    end
endmodule : adc_scan_trigger_control_tb_top
